/* File: include/eisf_pkg.sv */
package eisf_pkg;
    // System clock and the deglitch window; a longest time rounds down.
    localparam int unsigned SYS_CLK_KHZ = 40_000;
    localparam int unsigned SPIKE_NS = 50;
    localparam int unsigned FILT_CYCLES_RAW = SPIKE_NS * SYS_CLK_KHZ / 1_000_000;
    localparam int unsigned FILT_CYCLES = (FILT_CYCLES_RAW < 1) ? 1 : FILT_CYCLES_RAW;
    localparam int unsigned PIN_CYCLES = 1;
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned BUF_DEPTH = 2;
    // Device address byte layout.
    localparam logic [3:0] TYPE_ARRAY = 4'ha;
    localparam logic [3:0] TYPE_SPECIAL = 4'hb;
    localparam int unsigned TYPE_MSB = 7;
    localparam int unsigned TYPE_LSB = 4;
    localparam int unsigned CS_HIGH_POS = 3;
    localparam int unsigned CS_LOW_POS = 2;
    localparam int unsigned TOP_BIT_POS = 1;
    localparam int unsigned RW_POS = 0;
    // Bit counter values: eight data bits, then the ninth clock.
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ACK = 4'h8;
    localparam logic [3:0] CNT_DONE = 4'h9;
    // Values after reset.
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] WADDR_RST = 16'h0000;
    localparam logic [1:0] BUS_RST = 2'h3;
    localparam logic [3:0] PIN_RST = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV = 3'b001,
        ST_WA_HI = 3'b010,
        ST_WA_LO = 3'b011,
        ST_DATA = 3'b100,
        ST_IGNORE = 3'b101,
        ST_BUSY = 3'b110
    } eisf_state_type;
endpackage

/* File: include/eisf_byte_if.sv */
`timescale 1ns/1ps
interface eisf_byte_if #(parameter int unsigned W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: logic/eisf_deglitch.sv */
`timescale 1ns/1ps
module eisf_deglitch #(
    parameter int unsigned N = 2,
    parameter int unsigned CYC = eisf_pkg::FILT_CYCLES,
    parameter logic [N-1:0] RST = '1
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [N-1:0] i_line,
    output logic [N-1:0] o_line
);
    import eisf_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic [3:0] cnt;
        logic q;
    } eisf_dg_type;

    // Two flops first; only the second feeds the stability counter.
    for (genvar g = 0; g < N; g++) begin : g_line
        eisf_dg_type r_reg;
        eisf_dg_type r_next;
        always_comb begin
            r_next = r_reg;
            r_next.s1 = i_line[g];
            r_next.s2 = r_reg.s1;
            if (r_reg.s2 == r_reg.q) begin
                r_next.cnt = 4'h0;
            end else if (r_reg.cnt == 4'(CYC - 1)) begin
                r_next.q = r_reg.s2;
                r_next.cnt = 4'h0;
            end else begin
                r_next.cnt = r_reg.cnt + 4'h1;
            end
        end
        always_ff @(posedge i_sys_clk or posedge i_rst) begin
            if (i_rst) begin
                r_reg <= '{s1: RST[g], s2: RST[g], cnt: 4'h0, q: RST[g]};
            end else begin
                r_reg <= r_next;
            end
        end
        assign o_line[g] = r_reg.q;
    end
endmodule

/* File: logic/eisf_buffer.sv */
`timescale 1ns/1ps
module eisf_buffer #(
    parameter int unsigned W = eisf_pkg::DATA_BITS,
    parameter int unsigned DEPTH = eisf_pkg::BUF_DEPTH
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    eisf_byte_if.snk in_if,
    output logic o_valid,
    output logic [W-1:0] o_data,
    input wire logic i_ready
);
    import eisf_pkg::*;
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } eisf_buf_type;

    eisf_buf_type r_reg;
    eisf_buf_type r_next;
    logic push;
    logic pop;

    assign in_if.ready = (r_reg.cnt != (AW+1)'(DEPTH));
    assign o_valid = (r_reg.cnt != '0);
    assign o_data = r_reg.mem[r_reg.rp];
    assign push = in_if.valid && in_if.ready;
    assign pop = o_valid && i_ready;

    always_comb begin
        r_next = r_reg;
        if (push) begin
            r_next.mem[r_next.wp] = in_if.data;
            r_next.wp = (r_reg.wp == AW'(DEPTH - 1)) ? '0 : r_reg.wp + AW'(1);
        end
        if (pop) begin
            r_next.rp = (r_reg.rp == AW'(DEPTH - 1)) ? '0 : r_reg.rp + AW'(1);
        end
        if (push && !pop) begin
            r_next.cnt = r_reg.cnt + (AW+1)'(1);
        end else if (pop && !push) begin
            r_next.cnt = r_reg.cnt - (AW+1)'(1);
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    a_buf_no_loss: assert property (push && !pop |=> r_reg.cnt == $past(r_reg.cnt) + 1)
        else $error("buffer lost a pushed byte");
endmodule

/* File: logic/eisf_front_end.sv */
`timescale 1ns/1ps
// Operation
// - Sample on rising clock, drive after falling.
// - Bytes shift most significant bit first.
// - Each byte is eight bits plus acknowledge.
// - Data changes only while clock low.
// - Falling data with clock high is Start.
// - Ignore everything until a Start.
// - Rising data with clock high is Stop.
// - Stop after write starts write cycle.
// - Hold data low through the ninth clock.
// - Standby at power-up, after reads, after operations.
// - Standby after power-on reset; master waits.
// - Brown-out resets interface and silences it.
// - Write-protect pin blocks all writes.
// - Address byte: type, chip selects, bit one, direction.
// - Type 1010 selects array; bit one is top.
// - Type 1011 selects special page space.
// - Chip-select bits must equal the pins.
// - Lowest address bit one means read.
// - Acknowledge match; mismatch nacks, back to standby.
// - Two acknowledged word-address bytes, high first.
// - No byte-count limit between Start and Stop.
// - Under protection nack data, ack addresses.
// - Only Stop right after data acknowledge writes.
// - During write cycle ignore bus entirely.
module eisf_front_end #(
    parameter int unsigned FILT = eisf_pkg::FILT_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_chip_select_low_pin,
    input wire logic i_chip_select_high_pin,
    input wire logic i_write_protect,
    input wire logic i_power_good,
    input wire logic i_write_done,
    output logic o_write_start,
    output logic o_busy,
    output logic o_standby,
    output logic o_read,
    output logic o_special_space,
    output logic o_array_address_top_bit,
    output logic [15:0] o_word_addr,
    output logic o_data_valid,
    output logic [eisf_pkg::DATA_BITS-1:0] o_data,
    input wire logic i_data_ready
);
    import eisf_pkg::*;

    typedef struct packed {
        eisf_state_type st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic oe;
        logic rd;
        logic special;
        logic top;
        logic [15:0] waddr;
        logic armed;
        logic push;
        logic wstart;
        logic scl_q;
        logic sda_q;
    } eisf_fe_type;

    eisf_fe_type r_reg;
    eisf_fe_type r_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Input conditioning.

    logic [1:0] bus_f;
    logic [3:0] pin_f;
    logic scl;
    logic sda;
    logic cs_low;
    logic cs_high;
    logic wp;
    logic pg;

    // Spikes shorter than the filter window never reach the edge logic.
    eisf_deglitch #(.N(2), .CYC(FILT), .RST(BUS_RST)) u_bus_filt (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_line({i_sda, i_scl}),
        .o_line(bus_f)
    );

    // Static straps and the power monitor are also asynchronous to this clock.
    eisf_deglitch #(.N(4), .CYC(PIN_CYCLES), .RST(PIN_RST)) u_pin_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_line({i_power_good, i_write_protect, i_chip_select_high_pin,
                 i_chip_select_low_pin}),
        .o_line(pin_f)
    );

    assign scl = bus_f[0];
    assign sda = bus_f[1];
    assign cs_low = pin_f[0];
    assign cs_high = pin_f[1];
    assign wp = pin_f[2];
    assign pg = pin_f[3];

    ////////////////////////////////////////////////////////////////////////////////
    // Bus events.

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic addr_match;
    logic ack_ok;
    logic active;

    assign scl_rise = scl && !r_reg.scl_q;
    assign scl_fall = !scl && r_reg.scl_q;
    // Data moving while the clock stays high is a bus condition, not data.
    assign start_det = scl && r_reg.scl_q && r_reg.sda_q && !sda;
    assign stop_det = scl && r_reg.scl_q && !r_reg.sda_q && sda;

    // Both type codes are answered; the chip-select bits must equal the straps.
    assign addr_match = ((r_reg.sh[TYPE_MSB:TYPE_LSB] == TYPE_ARRAY) ||
                         (r_reg.sh[TYPE_MSB:TYPE_LSB] == TYPE_SPECIAL)) &&
                        (r_reg.sh[CS_HIGH_POS] == cs_high) &&
                        (r_reg.sh[CS_LOW_POS] == cs_low);

    // Declared ahead of the acknowledge decision, which reads the buffer's ready.
    eisf_byte_if #(.W(DATA_BITS)) bif ();

    always_comb begin
        case (r_reg.st)
            ST_DEV: ack_ok = addr_match;
            ST_WA_HI: ack_ok = 1'b1;
            ST_WA_LO: ack_ok = 1'b1;
            // A full buffer nacks rather than dropping the byte.
            ST_DATA: ack_ok = !wp && bif.ready;
            default: ack_ok = 1'b0;
        endcase
    end

    assign active = (r_reg.st != ST_IDLE) && (r_reg.st != ST_IGNORE);

    ////////////////////////////////////////////////////////////////////////////////
    // Protocol engine.

    always_comb begin
        r_next = r_reg;
        r_next.push = 1'b0;
        r_next.wstart = 1'b0;
        r_next.scl_q = scl;
        r_next.sda_q = sda;
        if (!pg) begin
            // Power loss drops to standby, clears the count, drive and armed flag, and keeps the device deaf.
            r_next.st = ST_IDLE;
            r_next.cnt = CNT_ZERO;
            r_next.oe = 1'b0;
            r_next.armed = 1'b0;
        end else if (r_reg.st == ST_BUSY) begin
            if (i_write_done) begin
                r_next.st = ST_IDLE;
            end
        end else if (start_det) begin
            // A Start restarts from any point outside the write cycle, which also serves bus recovery.
            r_next.st = ST_DEV;
            r_next.cnt = CNT_ZERO;
            r_next.oe = 1'b0;
            r_next.armed = 1'b0;
        end else if (stop_det) begin
            // Armed outlives only the rise that opens the tenth clock, so a Stop
            // in any later slot, or after a partial byte, starts nothing.
            if (r_reg.armed) begin
                r_next.st = ST_BUSY;
                r_next.wstart = 1'b1;
            end else begin
                r_next.st = ST_IDLE;
            end
            r_next.cnt = CNT_ZERO;
            r_next.oe = 1'b0;
            r_next.armed = 1'b0;
        end else if (active) begin
            if (scl_rise) begin
                if (r_reg.cnt < CNT_ACK) begin
                    r_next.sh = {r_reg.sh[6:0], sda};
                end
                r_next.cnt = r_reg.cnt + 4'h1;
                r_next.armed = r_reg.armed && (r_reg.cnt == CNT_ZERO);
            end else if (scl_fall && r_reg.cnt == CNT_ACK) begin
                // Drive after the eighth falling edge, hold across the ninth clock.
                r_next.oe = ack_ok;
                r_next.push = ack_ok && (r_reg.st == ST_DATA);
                case (r_reg.st)
                    ST_DEV: begin
                        r_next.rd = r_reg.sh[RW_POS];
                        r_next.special = (r_reg.sh[TYPE_MSB:TYPE_LSB] == TYPE_SPECIAL);
                        // Bit one is only an address bit for the main array.
                        r_next.top = r_next.special ? 1'b0 : r_reg.sh[TOP_BIT_POS];
                    end
                    ST_WA_HI: r_next.waddr[15:8] = r_reg.sh;
                    ST_WA_LO: r_next.waddr[7:0] = r_reg.sh;
                    default: r_next.waddr = r_reg.waddr;
                endcase
            end else if (scl_fall && r_reg.cnt == CNT_DONE) begin
                r_next.oe = 1'b0;
                r_next.cnt = CNT_ZERO;
                case (r_reg.st)
                    ST_DEV: begin
                        if (!r_reg.oe) begin
                            r_next.st = ST_IDLE;
                        end else if (r_reg.rd) begin
                            r_next.st = ST_IGNORE;
                        end else begin
                            r_next.st = ST_WA_HI;
                        end
                    end
                    ST_WA_HI: r_next.st = ST_WA_LO;
                    ST_WA_LO: r_next.st = ST_DATA;
                    // Any number of data bytes may follow.
                    ST_DATA: r_next.armed = r_reg.oe;
                    default: r_next.st = ST_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            r_reg <= '{st: ST_IDLE, cnt: CNT_ZERO, sh: BYTE_RST, oe: 1'b0, rd: 1'b0,
                       special: 1'b0, top: 1'b0, waddr: WADDR_RST, armed: 1'b0,
                       push: 1'b0, wstart: 1'b0, scl_q: 1'b1, sda_q: 1'b1};
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Received data stream.

    assign bif.valid = r_reg.push;
    assign bif.data = r_reg.sh;

    eisf_buffer #(.W(DATA_BITS), .DEPTH(BUF_DEPTH)) u_buf (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .in_if(bif),
        .o_valid(o_data_valid),
        .o_data(o_data),
        .i_ready(i_data_ready)
    );

    // Open drain: the pin is only ever pulled low.
    assign o_sda_out = 1'b0;
    assign o_sda_oe = r_reg.oe;
    assign o_write_start = r_reg.wstart;
    assign o_busy = (r_reg.st == ST_BUSY);
    assign o_standby = (r_reg.st == ST_IDLE);
    assign o_read = r_reg.rd;
    assign o_special_space = r_reg.special;
    assign o_array_address_top_bit = r_reg.top;
    assign o_word_addr = r_reg.waddr;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence s_ninth_drive;
        scl_fall && r_reg.cnt == CNT_ACK && active && pg && !start_det && !stop_det;
    endsequence

    sequence s_ninth_end;
        scl_fall && r_reg.cnt == CNT_DONE && active && pg && !start_det && !stop_det;
    endsequence

    a_ack_window: assert property (o_sda_oe |-> (r_reg.cnt == CNT_ACK || r_reg.cnt == CNT_DONE))
        else $error("acknowledge driven outside the ninth clock");

    a_drive_on_fall: assert property ($rose(o_sda_oe) |-> $past(scl_fall))
        else $error("data output changed away from a falling clock");

    a_mismatch_nack: assert property (s_ninth_drive ##0 r_reg.st == ST_DEV && !addr_match
                                      |=> !o_sda_oe ##0 r_reg.st == ST_DEV)
        else $error("mismatching address was acknowledged");

    a_match_ack: assert property (s_ninth_drive ##0 r_reg.st == ST_DEV && addr_match
                                  |=> o_sda_oe)
        else $error("matching address was not acknowledged");

    a_ack_release: assert property (s_ninth_end |=> !o_sda_oe && r_reg.cnt == CNT_ZERO)
        else $error("acknowledge not released after the ninth clock");

    a_start_seen: assert property (pg && start_det && !o_busy
                                   |=> r_reg.st == ST_DEV && r_reg.cnt == CNT_ZERO)
        else $error("start condition not taken");

    a_stop_ends: assert property (pg && stop_det && !o_busy
                                  |=> (o_standby || o_busy) && !o_sda_oe)
        else $error("stop condition did not end the transfer");

    a_write_cause: assert property ($rose(o_write_start)
                                    |-> $past(stop_det) && $past(r_reg.armed))
        else $error("write cycle started without a proper stop");

    a_wp_nack: assert property (s_ninth_drive ##0 r_reg.st == ST_DATA && wp
                                |=> !o_sda_oe ##1 !r_reg.armed)
        else $error("protected data byte was acknowledged");

    a_busy_silent: assert property (o_busy |-> !o_sda_oe)
        else $error("bus driven during the write cycle");

    a_power_down: assert property (!pg |=> o_standby && !o_sda_oe)
        else $error("interface alive without valid power");

    a_shift_msb: assert property (active && pg && scl_rise && r_reg.cnt < CNT_ACK
                                  && !start_det && !stop_det && !o_busy
                                  |=> r_reg.sh[0] == $past(sda))
        else $error("received bit not shifted in");

    // The write cycle must follow from an armed Stop, not only be caused by one.
    sequence s_write_slot;
        stop_det && r_reg.armed && pg && !o_busy;
    endsequence

    a_write_begin: assert property (s_write_slot |=> o_write_start && o_busy)
        else $error("armed stop did not start the write cycle");

    a_ack_hold: assert property (o_sda_oe && pg && !start_det && !stop_det
                                 && !(scl_fall && r_reg.cnt == CNT_DONE) |=> o_sda_oe)
        else $error("acknowledge dropped inside the ninth clock");

    a_busy_hold: assert property (o_busy && pg && !i_write_done |=> o_busy)
        else $error("write cycle left before it finished");

    a_idle_deaf: assert property (o_standby && pg && !start_det
                                  |=> o_standby && !o_sda_oe)
        else $error("standby device reacted without a start");

    a_push_acked: assert property (r_reg.push |-> o_sda_oe)
        else $error("byte stored without an acknowledge");
endmodule

/* File: sim/eisf_master_model.sv */
`timescale 1ns/1ps
module eisf_master_model (
    input wire logic i_sys_clk,
    input wire logic i_sda_line,
    output logic o_scl,
    output logic o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask

    // Works from a low clock as well, so it also serves as a repeated Start.
    task automatic start();
        o_sda = 1'b1;
        tick(2);
        o_scl = 1'b1;
        tick(3);
        o_sda = 1'b0;
        tick(3);
        o_scl = 1'b0;
        tick(2);
    endtask

    task automatic stop();
        o_sda = 1'b0;
        tick(2);
        o_scl = 1'b1;
        tick(3);
        o_sda = 1'b1;
        tick(6);
    endtask

    task automatic clock_low();
        o_scl = 1'b0;
        tick(4);
    endtask

    // One bit per 200 ns clock, data changed two cycles into the low phase.
    task automatic bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            o_sda = b[i];
            tick(2);
            o_scl = 1'b1;
            tick(4);
            o_scl = 1'b0;
            tick(2);
        end
    endtask

    // The low phase after the ninth clock is stretched: the slave's release
    // lags the pin by its filter delay and must land before the next data bit.
    task automatic xfer(input logic [7:0] b, output logic ack);
        logic s1;
        logic s2;
        bits(b, 8);
        o_sda = 1'b1;
        tick(2);
        o_scl = 1'b1;
        tick(2);
        s1 = i_sda_line;
        tick(2);
        s2 = i_sda_line;
        o_scl = 1'b0;
        tick(8);
        ack = ~(s1 | s2);
    endtask

    task automatic recover();
        logic ack;
        start();
        xfer(8'hff, ack);
        start();
        stop();
    endtask
endmodule

/* File: sim/eisf_front_end_test.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
module eisf_front_end_test;
    import eisf_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cs_lo = 1'b0;
    logic cs_hi = 1'b1;
    logic wp = 1'b0;
    logic pg = 1'b1;
    logic wr_done = 1'b0;
    logic rd_ready = 1'b0;
    logic scl, sda_m, sda_line, sda_out, sda_oe, write_start, busy, standby;
    logic rd, special, top_bit, data_valid, ack;
    logic [15:0] word_addr;
    logic [DATA_BITS-1:0] data;
    int bad_count = 0;
    int check_count = 0;
    int ws_count = 0;

    // Open-drain line with a pull-up: high unless the master or the slave pulls it low.
    assign sda_line = sda_m & (sda_oe ? sda_out : 1'b1);

    eisf_master_model u_master (.i_sys_clk(sys_clk), .i_sda_line(sda_line), .o_scl(scl),
        .o_sda(sda_m));

    eisf_front_end #(.FILT(1)) u_dut (.i_sys_clk(sys_clk), .i_rst(rst), .i_scl(scl),
        .i_sda(sda_line), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .i_chip_select_low_pin(cs_lo), .i_chip_select_high_pin(cs_hi),
        .i_write_protect(wp), .i_power_good(pg), .i_write_done(wr_done),
        .o_write_start(write_start), .o_busy(busy), .o_standby(standby), .o_read(rd),
        .o_special_space(special), .o_array_address_top_bit(top_bit),
        .o_word_addr(word_addr), .o_data_valid(data_valid), .o_data(data),
        .i_data_ready(rd_ready));

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (write_start === 1'b1) begin
            ws_count <= ws_count + 1;
        end
    end

    function automatic logic [7:0] dev(input logic [3:0] t, input logic top, input logic rw);
        return {t, cs_hi, cs_lo, top, rw};
    endfunction

    task automatic send(input logic [7:0] b, input logic exp);
        u_master.xfer(b, ack);
        `CHK(ack, exp)
    endtask

    task automatic pulse(ref logic s);
        @(negedge sys_clk) s = 1'b1;
        @(negedge sys_clk) s = 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic t_no_start();
        u_master.clock_low();
        send(dev(TYPE_ARRAY, 1'b0, 1'b1), 1'b0);
        u_master.recover();
        `CHK(standby, 1'b1)
    endtask

    task automatic t_read();
        int n = ws_count;
        u_master.start();
        send(dev(TYPE_ARRAY, 1'b0, 1'b1), 1'b1);
        `CHK(rd, 1'b1)
        `CHK(top_bit, 1'b0)
        u_master.stop();
        `CHK(ws_count, n)
        `CHK(standby, 1'b1)
    endtask

    task automatic t_write_ok();
        int n = ws_count;
        u_master.start();
        send(dev(TYPE_ARRAY, 1'b1, 1'b0), 1'b1);
        send(8'h5a, 1'b1);
        send(8'hc3, 1'b1);
        `CHK(word_addr, 16'h5ac3)
        `CHK(top_bit, 1'b1)
        `CHK(rd, 1'b0)
        `CHK(special, 1'b0)
        send(8'h96, 1'b1);
        `CHK(data_valid, 1'b1)
        `CHK(data, 8'h96)
        pulse(rd_ready);
        `CHK(data_valid, 1'b0)
        u_master.stop();
        `CHK(ws_count, n + 1)
        `CHK(busy, 1'b1)
        u_master.start();
        send(dev(TYPE_ARRAY, 1'b0, 1'b1), 1'b0);
        u_master.stop();
        `CHK(ws_count, n + 1)
        pulse(wr_done);
        `CHK(standby, 1'b1)
        `CHK(busy, 1'b0)
    endtask

    task automatic t_mismatch();
        logic [7:0] b;
        for (int i = 0; i < 4; i++) begin
            b = {(i == 0) ? 4'h9 : (i == 3) ? 4'hc : TYPE_ARRAY, cs_hi ^ (i == 1),
                cs_lo ^ (i == 2), 2'b00};
            u_master.start();
            send(b, 1'b0);
            `CHK(standby, 1'b1)
            send(8'h00, 1'b0);
            u_master.stop();
        end
    endtask

    task automatic t_protect();
        int n = ws_count;
        @(negedge sys_clk) wp = 1'b1;
        for (int k = 0; k < 2; k++) begin
            u_master.start();
            send(dev(k ? TYPE_SPECIAL : TYPE_ARRAY, 1'b0, 1'b0), 1'b1);
            `CHK(special, k[0])
            send(8'h04, 1'b1);
            send(8'h10, 1'b1);
            send(8'h3c, 1'b0);
            `CHK(data_valid, 1'b0)
            u_master.stop();
            `CHK(ws_count, n)
        end
        @(negedge sys_clk) wp = 1'b0;
    endtask

    task automatic t_buffer_partial();
        int n;
        u_master.start();
        send(dev(TYPE_ARRAY, 1'b0, 1'b0), 1'b1);
        send(8'h01, 1'b1);
        send(8'h02, 1'b1);
        send(8'ha1, 1'b1);
        send(8'hb2, 1'b1);
        send(8'hc3, 1'b0);
        `CHK(data, 8'ha1)
        pulse(rd_ready);
        `CHK(data, 8'hb2)
        pulse(rd_ready);
        `CHK(data_valid, 1'b0)
        send(8'hd4, 1'b1);
        n = ws_count;
        u_master.bits(8'h55, 4);
        u_master.stop();
        `CHK(ws_count, n)
        `CHK(data, 8'hd4)
        pulse(rd_ready);
        `CHK(data_valid, 1'b0)
    endtask

    task automatic t_brownout();
        u_master.start();
        send(dev(TYPE_ARRAY, 1'b0, 1'b0), 1'b1);
        @(negedge sys_clk) pg = 1'b0;
        repeat (4) @(negedge sys_clk);
        `CHK(standby, 1'b1)
        u_master.start();
        send(dev(TYPE_ARRAY, 1'b0, 1'b1), 1'b0);
        u_master.stop();
        @(negedge sys_clk) pg = 1'b1;
        repeat (8) @(negedge sys_clk);
        `CHK(standby, 1'b1)
        u_master.start();
        send(dev(TYPE_ARRAY, 1'b0, 1'b1), 1'b1);
        u_master.stop();
    endtask

    task automatic tally_and_finish();
        if (bad_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        repeat (6) @(negedge sys_clk);
        t_no_start();
        t_read();
        t_write_ok();
        t_mismatch();
        t_protect();
        t_buffer_partial();
        t_brownout();
        tally_and_finish();
    end

    // The whole sequence takes some 3,000 cycles; this allows ample margin.
    initial begin
        #1_000_000;
        bad_count++;
        tally_and_finish();
    end
endmodule
